// >>> ddal_regs.svh
// Constants for the decimal digit assist logic
`ifndef DDAL_REGS_SVH
`define DDAL_REGS_SVH
`define DDAL_EXCESS_DIGIT 4'h6
`define DDAL_NEG_SIGN_NIBBLE 4'h2
`define DDAL_ZONE_8BIT 4'hB
`define DDAL_ZONE_7BIT 4'h3
`define DDAL_ZERO_NIBBLE 4'h0
`define DDAL_DIGITS 4
`define DDAL_ALIGN_RST 2'h0
`define DDAL_COUNT_RST 2'h0
`define DDAL_WORD_RST 16'h0000
`define DDAL_ASCII_RST 32'h00000000
`define DDAL_MSN_POS 12
`define DDAL_SECOND_NIB_POS 8
`define DDAL_JUMP_RST 2'h0
`define DDAL_TRACK_N_RST 4'h0
`define DDAL_TRACK_RST 1'b1
`endif

// >>> ddal_pkg.sv
// Types for the decimal digit assist logic
package ddal_pkg;
   // Decimal ALU mode of the previous microinstruction
   typedef enum logic [1:0] {
      DDAL_POINT_ALIGN,
      DDAL_FETCH_MERGE,
      DDAL_UNLOAD_PACKED,
      DDAL_UNLOAD_UNPACKED
   } ddal_mode_t;
endpackage : ddal_pkg

// >>> ddal_core.sv
// Decimal digit assist logic: jump conditions, pack, excess-6 corrector, zero tracking
// Function
// - Operands are packed to BCD on entry and unpacked before storing when needed
// - Most significant digit sits at the lowest byte address
// - Arithmetic walks digits from least to most significant, high address downward
// - Alignment values give the byte position of the least significant digit
// - Jump condition decodes by the decimal ALU mode of the previous microinstruction
// - Point-align mode: jump condition equals destination alignment
// - Fetch-merge: count 0 gives 00, count above a+1 gives 11, else (n+3-a) mod 4
// - Unload packed: destination minus source alignment modulo 4
// - Unload unpacked: jump condition equals source alignment
// - Pack four ASCII digits from 32 bus bits into 16 BCD bits for ALU A
// - Negative sign under sign check puts 2 in the nibble the select chooses
// - Microcode touches the cache first, so packing never waits on a miss
// - Microcode adds 6 per digit before adding, making decimal carries natural
// - Corrector passes a carried nibble, else subtracts 6 modulo 16
// - Packed-correct gives 16-bit BCD; unpacked-correct expands to ASCII bytes
// - Four active-low nibble trackers NAND into one active-high zero track
// - Unpacked zone nibble is B in 8-bit mode, 3 in 7-bit mode
// - Trackers low with link 0; else match 6 or 0 over nibbles the condition picks
`timescale 1ns/1ps
`default_nettype none
`include "ddal_regs.svh"

module ddal_core import ddal_pkg::*; #(
   parameter int DIGITS = `DDAL_DIGITS
) (
   input wire logic clk, // 200 MHz processor clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic align_load, // Load the alignment flops
   input wire logic [1:0] dst_align_in, // Destination alignment of least significant digit
   input wire logic [1:0] src_align_in, // Source alignment of least significant digit
   input wire logic [1:0] byte_count_in, // Bytes left to process
   input wire logic mode_valid, // Current microinstruction names a decimal ALU mode
   input wire logic [1:0] alu_mode_in, // That mode code
   input wire logic [15:0] operand_bus_high, // Operand bus, high half
   input wire logic [15:0] operand_bus_low, // Operand bus, low half
   input wire logic sign_check_directive, // Check the sign while packing
   input wire logic sign_byte_select, // Sign sits in low byte of high bus
   input wire logic sign_is_negative, // Sign character decoded as negative
   input wire logic [15:0] high_alu_result, // Result from the high ALU slices
   input wire logic [3:0] high_alu_carry_out, // Per-nibble carry, bit 3 most significant
   input wire logic link, // Link bit
   input wire logic char_mode_8bit, // 1 for 8-bit characters, 0 for 7-bit
   output logic [1:0] decimal_jump_cond, // Two-bit decimal jump condition
   output logic [1:0] decimal_align_dst, // Destination alignment flops
   output logic [1:0] decimal_align_src, // Source alignment flops
   output logic [15:0] packed_operand, // Packed digits for ALU A input
   output logic [15:0] corrected_digits, // Packed-correct result
   output logic [31:0] unpacked_result, // Unpacked-correct ASCII result
   output logic [3:0] nibble_zero_track_n, // Per-nibble trackers, active low
   output logic zero_track // Nonzero digit skipped
);

   // The packed word and trackers are built for four digits only
   if (DIGITS != 4) begin : g_digit_check
      $error("ddal_core serves exactly four digits");
   end

   // Whole block state lives in one packed record
   typedef struct packed {
      logic [1:0] dst;
      logic [1:0] src;
      logic [1:0] cnt;
      ddal_mode_t mode;
      logic [1:0] jump;
      logic [15:0] packed_w;
      logic [15:0] corr;
      logic [31:0] ascii;
      logic [3:0] trk_n;
      logic trk;
   } ddal_state_t;

   ddal_state_t state_reg;
   ddal_state_t state_next;

   // Jump condition for one mode; a pure decode so no cycle is lost
   function automatic logic [1:0] ddal_jump_f(input ddal_mode_t m, input logic [1:0] a,
                                             input logic [1:0] s, input logic [1:0] n);
      logic [2:0] lim;
      lim = {1'b0, a} + 3'h1;
      unique case (m)
         DDAL_POINT_ALIGN: ddal_jump_f = a;
         DDAL_FETCH_MERGE: begin
            if (n == 2'h0) ddal_jump_f = 2'h0;
            else if ({1'b0, n} > lim) ddal_jump_f = 2'h3;
            else ddal_jump_f = 2'(n + 2'h3 - a);
         end
         DDAL_UNLOAD_PACKED: ddal_jump_f = 2'(a - s);
         DDAL_UNLOAD_UNPACKED: ddal_jump_f = s;
      endcase
   endfunction : ddal_jump_f

   // Excess-6 removal of one nibble
   function automatic logic [3:0] ddal_fix_f(input logic [3:0] nib, input logic c);
      ddal_fix_f = c ? nib : 4'(nib - `DDAL_EXCESS_DIGIT);
   endfunction : ddal_fix_f

   // Next-state logic
   always_comb begin
      logic [3:0] sel;
      logic [3:0] tgt;
      // Defaults keep both helpers free of latches
      sel = 4'h0;
      tgt = 4'h0;
      state_next = state_reg;
      // Alignment flops hold the least significant digit position
      if (align_load) begin
         state_next.dst = dst_align_in;
         state_next.src = src_align_in;
         state_next.cnt = byte_count_in;
      end
      // Mode latched so the following jump decodes by it
      if (mode_valid) state_next.mode = ddal_mode_t'(alu_mode_in);
      state_next.jump = ddal_jump_f(state_next.mode, state_next.dst,
                                    state_next.src, state_next.cnt);
      // Pack: keep the digit nibble of each byte, most significant at lowest address
      state_next.packed_w = {operand_bus_high[11:8], operand_bus_high[3:0],
                             operand_bus_low[11:8], operand_bus_low[3:0]};
      if (sign_check_directive && sign_is_negative) begin
         if (sign_byte_select)
            state_next.packed_w[`DDAL_SECOND_NIB_POS +: 4] = `DDAL_NEG_SIGN_NIBBLE;
         else
            state_next.packed_w[`DDAL_MSN_POS +: 4] = `DDAL_NEG_SIGN_NIBBLE;
      end
      // Correct every nibble and expand it in the same step
      for (int i = 0; i < 4; i++) begin
         state_next.corr[4*i +: 4] = ddal_fix_f(high_alu_result[4*i +: 4],
                                                high_alu_carry_out[i]);
         state_next.ascii[8*i +: 8] = {char_mode_8bit ? `DDAL_ZONE_8BIT : `DDAL_ZONE_7BIT,
                                       state_next.corr[4*i +: 4]};
      end
      // Nibbles checked: all, low two, or low three
      unique case (state_next.jump)
         2'h0: sel = 4'hF;
         2'h1, 2'h2: sel = 4'h3;
         2'h3: sel = 4'h7;
      endcase
      // Unchecked nibbles read as matching so only selected digits count
      for (int i = 0; i < 4; i++) begin
         tgt = high_alu_carry_out[i] ? `DDAL_ZERO_NIBBLE : `DDAL_EXCESS_DIGIT;
         state_next.trk_n[i] = link & (~sel[i] | (high_alu_result[4*i +: 4] == tgt));
      end
      // Any unmatched checked nibble means a nonzero digit was skipped
      state_next.trk = ~&state_next.trk_n;
   end

   // State register; digits walk from high address down under microcode control
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '{dst: `DDAL_ALIGN_RST, src: `DDAL_ALIGN_RST, cnt: `DDAL_COUNT_RST,
                        mode: DDAL_POINT_ALIGN, jump: `DDAL_JUMP_RST, packed_w: `DDAL_WORD_RST,
                        corr: `DDAL_WORD_RST, ascii: `DDAL_ASCII_RST, trk_n: `DDAL_TRACK_N_RST,
                        trk: `DDAL_TRACK_RST};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state flops; pack has no stall path, cache is hit first
   assign decimal_jump_cond = state_reg.jump;
   assign decimal_align_dst = state_reg.dst;
   assign decimal_align_src = state_reg.src;
   assign packed_operand = state_reg.packed_w;
   assign corrected_digits = state_reg.corr;
   assign unpacked_result = state_reg.ascii;
   assign nibble_zero_track_n = state_reg.trk_n;
   assign zero_track = state_reg.trk;

   // Checks on the registered outputs
   // Mode checks read the latched mode, just as the jump decode does
   property p_point;
      @(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_POINT_ALIGN |-> decimal_jump_cond == state_reg.dst;
   endproperty
   a_point: assert property (p_point) else $error("point-align jump wrong");

   property p_fetch_zero;
      @(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_FETCH_MERGE && state_reg.cnt == 2'h0 |-> decimal_jump_cond == 2'h0;
   endproperty
   a_fetch_zero: assert property (p_fetch_zero) else $error("fetch-merge zero wrong");

   property p_fetch_over;
      @(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_FETCH_MERGE && state_reg.cnt != 2'h0
         && {1'b0, state_reg.cnt} > ({1'b0, state_reg.dst} + 3'h1) |-> decimal_jump_cond == 2'h3;
   endproperty
   a_fetch_over: assert property (p_fetch_over) else $error("fetch-merge overrun wrong");

   property p_unl_pk;
      @(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_UNLOAD_PACKED |->
         decimal_jump_cond == 2'(state_reg.dst - state_reg.src);
   endproperty
   a_unl_pk: assert property (p_unl_pk) else $error("unload packed jump wrong");

   property p_unl_up;
      @(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_UNLOAD_UNPACKED |-> decimal_jump_cond == state_reg.src;
   endproperty
   a_unl_up: assert property (p_unl_up) else $error("unload unpacked jump wrong");

   property p_pack;
      @(posedge clk) disable iff (!rst_b)
      !sign_check_directive |=> packed_operand == {$past(operand_bus_high[11:8]),
         $past(operand_bus_high[3:0]), $past(operand_bus_low[11:8]), $past(operand_bus_low[3:0])};
   endproperty
   a_pack: assert property (p_pack) else $error("pack result wrong");

   property p_sign;
      @(posedge clk) disable iff (!rst_b)
      sign_check_directive && sign_is_negative && !sign_byte_select
         |=> packed_operand[15:12] == 4'h2;
   endproperty
   a_sign: assert property (p_sign) else $error("sign nibble wrong");

   property p_corr;
      @(posedge clk) disable iff (!rst_b)
      !high_alu_carry_out[0] |=> corrected_digits[3:0] == 4'($past(high_alu_result[3:0]) - 4'h6);
   endproperty
   a_corr: assert property (p_corr) else $error("excess-6 removal wrong");

   property p_zone;
      @(posedge clk) disable iff (!rst_b)
      1'b1 |=> unpacked_result[7:0] == {($past(char_mode_8bit) ? 4'hB : 4'h3),
                                        corrected_digits[3:0]};
   endproperty
   a_zone: assert property (p_zone) else $error("zone nibble wrong");

   property p_track;
      @(posedge clk) disable iff (!rst_b)
      !link |=> nibble_zero_track_n == 4'h0 && zero_track;
   endproperty
   a_track: assert property (p_track) else $error("zero track with link low wrong");

   // Latching checks seen at the ports: a new mode steers the next jump; fetch-merge remainder reads the latched state
   property p_point_next;
      @(posedge clk) disable iff (!rst_b)
      mode_valid && alu_mode_in == 2'h0 |=> decimal_jump_cond == decimal_align_dst;
   endproperty
   a_point_next: assert property (p_point_next) else $error("point-align latch wrong");

   property p_fetch_mid;
      @(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_FETCH_MERGE && state_reg.cnt != 2'h0
         && {1'b0, state_reg.cnt} <= ({1'b0, state_reg.dst} + 3'h1)
         |-> decimal_jump_cond == 2'(state_reg.cnt + 2'h3 - state_reg.dst);
   endproperty
   a_fetch_mid: assert property (p_fetch_mid) else $error("fetch-merge remainder wrong");

   property p_unl_pk_next;
      @(posedge clk) disable iff (!rst_b)
      mode_valid && alu_mode_in == 2'h2 |=>
         decimal_jump_cond == 2'(decimal_align_dst - decimal_align_src);
   endproperty
   a_unl_pk_next: assert property (p_unl_pk_next) else $error("unload packed latch");

   property p_unl_up_next;
      @(posedge clk) disable iff (!rst_b)
      mode_valid && alu_mode_in == 2'h3 |=> decimal_jump_cond == decimal_align_src;
   endproperty
   a_unl_up_next: assert property (p_unl_up_next) else $error("unload unpacked latch");

   // Alignment flops load on request and otherwise hold across the whole digit walk
   property p_align_load;
      @(posedge clk) disable iff (!rst_b)
      align_load |=> decimal_align_dst == $past(dst_align_in)
         && decimal_align_src == $past(src_align_in);
   endproperty
   a_align_load: assert property (p_align_load) else $error("alignment load wrong");

   property p_align_hold;
      @(posedge clk) disable iff (!rst_b)
      !align_load |=> $stable(decimal_align_dst) && $stable(decimal_align_src);
   endproperty
   a_align_hold: assert property (p_align_hold) else $error("alignment drifted");

   // Low-byte sign lands in the second nibble, leaving the top digit alone
   property p_sign_low;
      @(posedge clk) disable iff (!rst_b)
      sign_check_directive && sign_is_negative && sign_byte_select
         |=> packed_operand[11:8] == 4'h2
         && packed_operand[15:12] == $past(operand_bus_high[11:8]);
   endproperty
   a_sign_low: assert property (p_sign_low) else $error("low-byte sign nibble wrong");

   // A carried nibble passes the corrector untouched
   property p_corr_pass;
      @(posedge clk) disable iff (!rst_b)
      high_alu_carry_out[3] |=> corrected_digits[15:12] == $past(high_alu_result[15:12]);
   endproperty
   a_corr_pass: assert property (p_corr_pass) else $error("carried nibble altered");

   // Expansion reuses the corrected digits of the same step, zone on top
   property p_unpack;
      @(posedge clk) disable iff (!rst_b)
      unpacked_result[27:24] == corrected_digits[15:12]
         && unpacked_result[19:16] == corrected_digits[11:8]
         && unpacked_result[11:8] == corrected_digits[7:4];
   endproperty
   a_unpack: assert property (p_unpack) else $error("expanded digit wrong");

   property p_zone_hi;
      @(posedge clk) disable iff (!rst_b)
      1'b1 |=> unpacked_result[31:28] == ($past(char_mode_8bit) ? 4'hB : 4'h3);
   endproperty
   a_zone_hi: assert property (p_zone_hi) else $error("top zone nibble wrong");

   // Full matches clear the skip flag; a stray low digit raises it
   property p_track_six;
      @(posedge clk) disable iff (!rst_b)
      link && high_alu_result == 16'h6666 && high_alu_carry_out == 4'h0
         |=> nibble_zero_track_n == 4'hF && !zero_track;
   endproperty
   a_track_six: assert property (p_track_six) else $error("all-six match missed");

   property p_track_hit0;
      @(posedge clk) disable iff (!rst_b)
      link && high_alu_carry_out[0] && high_alu_result[3:0] == 4'h0 |=> nibble_zero_track_n[0];
   endproperty
   a_track_hit0: assert property (p_track_hit0) else $error("carried zero missed");

   property p_track_miss;
      @(posedge clk) disable iff (!rst_b)
      link && !high_alu_carry_out[0] && high_alu_result[3:0] != 4'h6
         |=> !nibble_zero_track_n[0] && zero_track;
   endproperty
   a_track_miss: assert property (p_track_miss) else $error("skip not flagged");

   // Main scenarios worth seeing at least once
   c_fetch_merge: cover property (@(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_FETCH_MERGE && decimal_jump_cond == 2'h2);
   c_neg_low: cover property (@(posedge clk) disable iff (!rst_b)
      sign_check_directive && sign_is_negative && sign_byte_select);
   c_no_skip: cover property (@(posedge clk) disable iff (!rst_b) link ##1 !zero_track);
   c_unl_pk: cover property (@(posedge clk) disable iff (!rst_b)
      state_reg.mode == DDAL_UNLOAD_PACKED && decimal_jump_cond == 2'h3);
   c_track_hit: cover property (@(posedge clk) disable iff (!rst_b)
      link && high_alu_carry_out == 4'hF && high_alu_result == 16'h0000);

endmodule : ddal_core
`default_nettype wire

// >>> ddal_alu_model.sv
// High ALU slices seen from the corrector: add with one operand in excess 6
`timescale 1ns/1ps
`default_nettype none
module ddal_alu_model (
   input wire logic [15:0] op_a, // Packed BCD operand, unbiased; the model adds the 6 itself
   input wire logic [15:0] op_b, // Packed BCD operand
   output logic [15:0] result, // Binary nibble sum
   output logic [3:0] carry // Carry out of each nibble
);
   logic [4:0] sum;
   // Ripple upward so each nibble carry is a true decimal carry
   always_comb begin
      result = 16'h0000;
      carry = 4'h0;
      sum = 5'h00;
      for (int i = 0; i < 4; i++) begin
         sum = op_a[4*i+:4] + 5'h06 + op_b[4*i+:4] + sum[4];
         result[4*i+:4] = sum[3:0];
         carry[i] = sum[4];
      end
   end
endmodule : ddal_alu_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the decimal digit assist logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [1:0] jc;
      logic [1:0] dst;
      logic [1:0] src;
      logic [15:0] pk;
      logic [15:0] cor;
      logic [31:0] unp;
      logic [3:0] ztn;
      logic zt;
   } ddal_exp_t;
   logic clk = 1'b0;
   logic rst_b, align_load, mode_valid, chk, sel, neg, link, c8;
   logic [1:0] dst_in, src_in, cnt_in, mode_in, m_dst, m_src, m_cnt, m_mode;
   logic [15:0] bus_h, bus_l, op_a, op_b, res;
   logic [3:0] cy;
   wire ddal_exp_t got;
   ddal_exp_t q[$];
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   ddal_alu_model far (.op_a(op_a), .op_b(op_b), .result(res), .carry(cy));
   ddal_core uut (.clk(clk), .rst_b(rst_b), .align_load(align_load), .dst_align_in(dst_in),
      .src_align_in(src_in), .byte_count_in(cnt_in), .mode_valid(mode_valid),
      .alu_mode_in(mode_in), .operand_bus_high(bus_h), .operand_bus_low(bus_l),
      .sign_check_directive(chk), .sign_byte_select(sel), .sign_is_negative(neg),
      .high_alu_result(res), .high_alu_carry_out(cy), .link(link), .char_mode_8bit(c8),
      .decimal_jump_cond(got.jc), .decimal_align_dst(got.dst), .decimal_align_src(got.src),
      .packed_operand(got.pk), .corrected_digits(got.cor), .unpacked_result(got.unp),
      .nibble_zero_track_n(got.ztn), .zero_track(got.zt));
   // Jump condition from alignments, count and the last named mode
   function automatic logic [1:0] jump_of(input logic [1:0] d, s, n, m);
      case (m)
         2'h0: return d;
         2'h1: return (n == 2'h0) ? 2'h0 : ({1'b0, n} > {1'b0, d} + 3'h1) ? 2'h3
                      : n + 2'h3 - d;
         2'h2: return d - s;
         default: return s;
      endcase
   endfunction : jump_of
   function automatic logic [15:0] bcd();
      logic [15:0] v;
      for (int i = 0; i < 4; i++) v[4*i+:4] = 4'($urandom_range(9));
      return v;
   endfunction : bcd
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   // Shared reporting for the compare tasks below
   task automatic tally(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : tally
   // Jump condition with both alignment flops
   task automatic cmp_jump(input ddal_exp_t g, input ddal_exp_t e);
      tally(64'({g.jc, g.dst, g.src}), 64'({e.jc, e.dst, e.src}));
   endtask : cmp_jump
   task automatic cmp_pack(input ddal_exp_t g, input ddal_exp_t e);
      tally(64'(g.pk), 64'(e.pk));
   endtask : cmp_pack
   task automatic cmp_corr(input ddal_exp_t g, input ddal_exp_t e);
      tally(64'({g.cor, g.unp}), 64'({e.cor, e.unp}));
   endtask : cmp_corr
   task automatic cmp_track(input ddal_exp_t g, input ddal_exp_t e);
      tally(64'({g.ztn, g.zt}), 64'({e.ztn, e.zt}));
   endtask : cmp_track
   // Work out the outputs due one edge after the inputs just driven
   task automatic note();
      ddal_exp_t e;
      logic [3:0] nib;
      int nchk;
      #1;
      if (align_load) {m_dst, m_src, m_cnt} = {dst_in, src_in, cnt_in};
      if (mode_valid) m_mode = mode_in;
      e.jc = jump_of(m_dst, m_src, m_cnt, m_mode);
      {e.dst, e.src} = {m_dst, m_src};
      e.pk = {bus_h[11:8], bus_h[3:0], bus_l[11:8], bus_l[3:0]};
      if (chk && neg && sel) e.pk[11:8] = 4'h2;
      if (chk && neg && !sel) e.pk[15:12] = 4'h2;
      nchk = (e.jc == 2'h0) ? 4 : (e.jc == 2'h3) ? 3 : 2;
      for (int i = 0; i < 4; i++) begin
         nib = cy[i] ? res[4*i+:4] : res[4*i+:4] - 4'h6;
         e.cor[4*i+:4] = nib;
         e.unp[8*i+:8] = {c8 ? 4'hB : 4'h3, nib};
         e.ztn[i] = link && (i >= nchk || res[4*i+:4] == (cy[i] ? 4'h0 : 4'h6));
      end
      e.zt = ~&e.ztn;
      q.push_back(e);
   endtask : note
   // Each input written once per call; fix pins the control field to ctl
   task automatic rand_all(input bit fix, input logic [9:0] ctl);
      {chk, sel, neg, link, c8} = 5'($urandom);
      {align_load, mode_valid, mode_in, dst_in, src_in, cnt_in} = fix ? ctl : 10'($urandom);
      {bus_h, bus_l} = $urandom;
      op_a = bcd();
      op_b = bcd();
   endtask : rand_all
   // Reset clears flops and mode; outputs idle with the zero track high
   task automatic do_reset();
      ddal_exp_t e;
      e = {6'h00, 16'h0000, 16'h0000, 32'h00000000, 4'h0, 1'b1};
      rst_b = 1'b0;
      {m_dst, m_src, m_cnt, m_mode} = 8'h00;
      repeat (12) @(negedge clk);
      cmp_jump(got, e);
      cmp_pack(got, e);
      cmp_corr(got, e);
      cmp_track(got, e);
      rst_b = 1'b1;
   endtask : do_reset
   // Oldest note against what the outputs show after each edge
   always @(posedge clk) begin
      ddal_exp_t e;
      if (rst_b === 1'b1 && q.size() > 0) begin
         #1;
         e = q.pop_front();
         cmp_jump(got, e);
         cmp_pack(got, e);
         cmp_corr(got, e);
         cmp_track(got, e);
      end
   end
   // Hang guard, well above the expected run of about 2300 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      {align_load, mode_valid, chk, sel, neg, link, c8} = 7'h00;
      {dst_in, src_in, cnt_in, mode_in, bus_h, bus_l, op_a, op_b} = 72'h0;
      void'($urandom(64));
      do_reset();
      // Worked sum 0109 + 0005 from 8-bit characters, fetch-merge mode
      @(negedge clk);
      {align_load, dst_in, src_in, cnt_in, mode_valid, mode_in} = {1'b1, 6'h12, 1'b1, 2'h1};
      {bus_h, bus_l, op_a, op_b, c8} = {32'hB0B1B0B9, 16'h0109, 16'h0005, 1'b1};
      note();
      // Every mode against every alignment pair and count
      for (int k = 0; k < 256; k++) begin
         @(negedge clk);
         rand_all(1'b1, {2'b11, 8'(k)});
         note();
      end
      // All sixes without carry, then all zeros with carry, under each mode
      for (int k = 0; k < 8; k++) begin
         @(negedge clk);
         {align_load, mode_valid, mode_in, link} = {2'b01, 2'(k >> 1), 1'b1};
         {op_a, op_b} = k[0] ? {16'h9999, 16'h0001} : 32'h00000000;
         note();
      end
      // Random traffic; modes and alignments often held across cycles
      for (int k = 0; k < 2000; k++) begin
         @(negedge clk);
         rand_all(1'b0, 10'h000);
         note();
      end
      // Second reset at the end of the run, just before finishing
      @(negedge clk);
      do_reset();
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
